// >>> hdl/irqx_pkg.sv
// irqx_pkg: constants shared by the interrupt expander and its vector store
// assumes one clock domain; vectors are 32-bit handler addresses
package irqx_pkg;
    localparam int GROUPS = 12;
    localparam int PER_GROUP = 8;
    localparam int SOURCES = GROUPS * PER_GROUP;
    localparam int SRC_W = 7;
    localparam int VEC_W = 32;
    // word address of group 1 position 1 and last slot of group 12
    localparam logic [15:0] VEC_BASE_ADDR = 16'h0d40;
    localparam logic [15:0] VEC_LAST_ADDR = 16'h0dfe;
    localparam logic [15:0] GROUP_STRIDE = 16'h0010;
    localparam logic [15:0] POS_STRIDE = 16'h0002;
    // service sequence length in cpu cycles
    localparam int SERVICE_CYCLES = 8;
    localparam int SVC_CNT_W = 3;
    // wired source map: 1 = peripheral present, bit 8*g+p (0-based)
    localparam logic [95:0] WIRED_MASK = {
        8'hfb, 8'h0f, 8'hff, 8'h03, 8'h03, 8'h3f,
        8'h33, 8'h87, 8'hbf, 8'hff, 8'hff, 8'hdb
    };
    localparam logic [SOURCES-1:0] ENABLE_RESET = '0;
    typedef enum logic [2:0] {
        IRQX_IDLE = 3'b001,
        IRQX_FETCH = 3'b010,
        IRQX_SAVE = 3'b100
    } irqx_state_type;
endpackage : irqx_pkg

// >>> hdl/irqx_vector_ram.sv
// irqx_vector_ram: one vector word per source, registered read port
// assumes write and read come from the same clock domain
`timescale 1ns/1ps
module irqx_vector_ram
    import irqx_pkg::*;
#(
    parameter int DEPTH = SOURCES,
    parameter int AW = SRC_W,
    parameter int DW = VEC_W
)
(
    // clock
    input wire logic clk,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // read port
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] rd_data_q;

    // no reset on the array so it maps onto real ram
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en)
        begin
            rd_data_q <= mem[rd_addr];
        end
    end

    assign rd_data = rd_data_q;
endmodule : irqx_vector_ram

// >>> hdl/irqx_expander.sv
// irqx_expander: 96 sources in 12 groups of 8 onto 12 cpu request lines
// assumes sources are synchronous pulses on clk; vector writes come from
// the cpu side on clk; the cpu acks one group at a time
`timescale 1ns/1ps
module irqx_expander
    import irqx_pkg::*;
#(
    parameter int N_GROUPS = GROUPS,
    parameter int N_PER = PER_GROUP
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // peripheral sources and software raise
    input wire logic [SOURCES-1:0] src_irq,
    input wire logic [SOURCES-1:0] sw_raise,
    // per-source enables
    input wire logic [SOURCES-1:0] src_enable,
    // vector ram write, word address as mapped
    input wire logic vec_wr_en,
    input wire logic [15:0] vec_wr_addr,
    input wire logic [VEC_W-1:0] vec_wr_data,
    // cpu request lines and service handshake
    output logic [N_GROUPS-1:0] cpu_request,
    input wire logic service_ack,
    output logic service_busy,
    output logic vector_valid,
    output logic [VEC_W-1:0] vector_out,
    output logic [3:0] vector_group,
    output logic [2:0] vector_pos,
    output logic handler_start,
    // pending flags for software visibility
    output logic [SOURCES-1:0] pending_flags
);
    irqx_state_type state_q, state_d;
    logic [SOURCES-1:0] pend_q, pend_d;
    logic [SVC_CNT_W-1:0] cnt_q, cnt_d;
    logic [SRC_W-1:0] sel_q, sel_d;
    logic [SRC_W-1:0] win_idx;
    logic win_any;
    logic [SOURCES-1:0] eligible;
    logic [SOURCES-1:0] raise_ok;
    logic wr_ok;
    logic [SRC_W-1:0] wr_idx;
    logic [VEC_W-1:0] ram_rd;
    logic vec_valid_q, vec_valid_d;
    logic start_q, start_d;
    // vector word held from one fetch to the next
    logic [VEC_W-1:0] vec_q, vec_d;

    // word address to source index; odd or out-of-range gives no write
    function automatic logic [SRC_W:0] addr_to_idx(input logic [15:0] a);
        logic [15:0] off;
        off = a - VEC_BASE_ADDR;
        if (a < VEC_BASE_ADDR || a > VEC_LAST_ADDR || off[0])
            addr_to_idx = '0;
        else
            addr_to_idx = {1'b1, off[SRC_W:1]};
    endfunction : addr_to_idx

    // software raise only where the group has no wired peripheral active;
    // a raise in a cycle where a wired source of the group fires is
    // dropped, since a hand-set group flag could hide that event
    genvar g;
    generate
        for (g = 0; g < N_GROUPS; g++)
        begin : g_grp
            logic busy;
            assign busy = |(src_irq[g*N_PER +: N_PER]
                & WIRED_MASK[g*N_PER +: N_PER]);
            assign raise_ok[g*N_PER +: N_PER] = busy ? '0
                : sw_raise[g*N_PER +: N_PER];
            assign eligible[g*N_PER +: N_PER] = pend_q[g*N_PER +: N_PER]
                & src_enable[g*N_PER +: N_PER];
            // combinational, so a line falls in the cycle its last flag
            // clears and the cpu never sees a stale request
            assign cpu_request[g] = |eligible[g*N_PER +: N_PER];
        end
    endgenerate

    // fixed order: lowest index is group 1 position 1
    // scanned downward so the last hit, the lowest index, is kept; a
    // long chain, but its result is only used at the next edge
    always_comb
    begin
        win_any = 1'b0;
        win_idx = '0;
        for (int i = SOURCES - 1; i >= 0; i--)
        begin
            if (eligible[i])
            begin
                win_any = 1'b1;
                win_idx = SRC_W'(i);
            end
        end
    end

    assign {wr_ok, wr_idx} = addr_to_idx(vec_wr_addr);

    // the ram reads the current winner on every idle edge, so its word
    // stands one edge after the take; rewriting that slot on the taking
    // edge still hands out the old word
    irqx_vector_ram #(
        .DEPTH(SOURCES),
        .AW(SRC_W),
        .DW(VEC_W)
    ) u_ram (
        .clk(clk),
        .wr_en(vec_wr_en & wr_ok),
        .wr_addr(wr_idx),
        .wr_data(vec_wr_data),
        .rd_en(state_q == IRQX_IDLE),
        .rd_addr(win_idx),
        .rd_data(ram_rd)
    );

    // service walk, counted from the taking edge:
    //   edge 0 latches the winner and reads its ram word
    //   edge 1 registers the vector, pulses valid, clears the flag
    //   edges 2 to 7 stand for the cpu saving its registers
    //   edge 8 pulses handler start and frees the sequencer
    // the counter runs through fetch and save so eight edges pass
    // service sequencer and pending flags
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        sel_d = sel_q;
        vec_valid_d = 1'b0;
        start_d = 1'b0;
        vec_d = vec_q;
        // unwired positions can only be set by software
        pend_d = pend_q | ((src_irq & WIRED_MASK) | raise_ok);
        case (state_q)
            IRQX_IDLE:
            begin
                if (service_ack && win_any)
                begin
                    state_d = IRQX_FETCH;
                    sel_d = win_idx;
                    cnt_d = '0;
                end
            end
            IRQX_FETCH:
            begin
                vec_valid_d = 1'b1;
                // clear only the fetched flag; a new event this cycle wins,
                // a wired pulse and a software raise alike
                pend_d[sel_q] = (src_irq[sel_q] & WIRED_MASK[sel_q])
                    | raise_ok[sel_q];
                vec_d = ram_rd;
                state_d = IRQX_SAVE;
                cnt_d = cnt_q + 1'b1;
            end
            IRQX_SAVE:
            begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == SVC_CNT_W'(SERVICE_CYCLES - 1))
                begin
                    start_d = 1'b1;
                    state_d = IRQX_IDLE;
                    cnt_d = '0;
                end
            end
            default:
            begin
                state_d = IRQX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= IRQX_IDLE;
            pend_q <= '0;
            cnt_q <= '0;
            sel_q <= '0;
            vec_valid_q <= 1'b0;
            start_q <= 1'b0;
            vec_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            pend_q <= pend_d;
            cnt_q <= cnt_d;
            sel_q <= sel_d;
            vec_valid_q <= vec_valid_d;
            start_q <= start_d;
            vec_q <= vec_d;
        end
    end

    // vector word holds until the next fetch and source index until the next take,
    // so the cpu may read them late; valid and start last one cycle each
    assign vector_out = vec_q;
    assign vector_valid = vec_valid_q;
    assign vector_group = 4'(sel_q >> 3);
    assign vector_pos = sel_q[2:0];
    assign handler_start = start_q;
    assign service_busy = (state_q != IRQX_IDLE);
    assign pending_flags = pend_q;
endmodule : irqx_expander

// >>> testbench/irqx_expander_assertions.sv
// irqx_checker: port-level service and request properties
// assumes bind onto irqx_expander, one clock domain
`timescale 1ns/1ps
module irqx_checker
    import irqx_pkg::*;
#(
    parameter int N_GROUPS = GROUPS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched signals
    input wire logic [SOURCES-1:0] src_enable,
    input wire logic [SOURCES-1:0] pending_flags,
    input wire logic [N_GROUPS-1:0] cpu_request,
    input wire logic service_ack,
    input wire logic service_busy,
    input wire logic vector_valid,
    input wire logic handler_start
);
    wire logic [SOURCES-1:0] live = pending_flags & src_enable;
    // one request line per group of eight
    function automatic logic [N_GROUPS-1:0] grp(input logic [95:0] v);
        for (int g = 0; g < N_GROUPS; g++)
        begin
            grp[g] = |v[g*8+:8];
        end
    endfunction : grp
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_take; !service_busy && service_ack && |live; endsequence
    sequence s_run; service_busy[*8] ##1 !service_busy; endsequence
    property p_req; cpu_request == grp(live); endproperty
    a_req: assert property (p_req) else $error("request mismatch");
    property p_fetch; s_take |=> service_busy ##1 vector_valid; endproperty
    a_fetch: assert property (p_fetch) else $error("late vector");
    property p_len; s_take |=> s_run ##0 handler_start; endproperty
    a_len: assert property (p_len) else $error("service length");
    property p_vpulse; vector_valid |=> !vector_valid; endproperty
    a_vpulse: assert property (p_vpulse) else $error("valid long");
    property p_spulse; handler_start |=> !handler_start; endproperty
    a_spulse: assert property (p_spulse) else $error("start long");
    property p_vbusy; vector_valid |-> $past(service_busy); endproperty
    a_vbusy: assert property (p_vbusy) else $error("stray valid");
    property p_idle; !service_busy && !service_ack |=> !service_busy;
    endproperty
    a_idle: assert property (p_idle) else $error("start unasked");
    property p_sbusy; handler_start |-> $past(service_busy); endproperty
    a_sbusy: assert property (p_sbusy) else $error("stray start");
endmodule : irqx_checker
bind irqx_expander irqx_checker #(.N_GROUPS(N_GROUPS)) u_chk (
    .clk(clk), .rst_n(rst_n), .src_enable(src_enable),
    .pending_flags(pending_flags), .cpu_request(cpu_request),
    .service_ack(service_ack), .service_busy(service_busy),
    .vector_valid(vector_valid), .handler_start(handler_start)
);

// >>> testbench/irqx_cpu_model.sv
// irqx_cpu_model: cpu side, acks a raised line after lag cycles
// assumes request and busy come from the expander on clk
`timescale 1ns/1ps
module irqx_cpu_model
(
    // clock and pacing
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] lag,
    // expander side
    input wire logic [11:0] cpu_request,
    input wire logic service_busy,
    output logic service_ack
);
    logic [3:0] wait_q;
    // one ack pulse per service, never while the expander is busy
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_q <= 4'h0;
            service_ack <= 1'b0;
        end
        else
        begin
            wait_q <= (|cpu_request && !service_busy) ? wait_q + 4'h1 : 4'h0;
            service_ack <= |cpu_request && !service_busy && !service_ack
                && wait_q >= lag;
        end
    end
endmodule : irqx_cpu_model

// >>> testbench/test_irqx_expander.sv
// test_irqx_expander: directed service, priority and enable scenarios
// assumes the cpu model answers every raised request line
`timescale 1ns/1ps
module test_irqx_expander;
    import irqx_pkg::*;
    logic clk, rst_n, vec_wr_en, service_ack, service_busy;
    logic vector_valid, handler_start;
    logic [95:0] src_irq, src_enable, sw_raise, pending_flags;
    logic [15:0] vec_wr_addr;
    logic [31:0] vec_wr_data, vector_out;
    logic [11:0] cpu_request;
    logic [3:0] vector_group, lag;
    logic [2:0] vector_pos;
    int err_total, n_checks;
    irqx_expander uut (.clk(clk), .rst_n(rst_n), .src_irq(src_irq),
        .sw_raise(sw_raise), .src_enable(src_enable),
        .vec_wr_en(vec_wr_en), .vec_wr_addr(vec_wr_addr),
        .vec_wr_data(vec_wr_data), .cpu_request(cpu_request),
        .service_ack(service_ack), .service_busy(service_busy),
        .vector_valid(vector_valid), .vector_out(vector_out),
        .vector_group(vector_group), .vector_pos(vector_pos),
        .handler_start(handler_start), .pending_flags(pending_flags));
    irqx_cpu_model cpu (.clk(clk), .rst_n(rst_n), .lag(lag),
        .cpu_request(cpu_request), .service_busy(service_busy),
        .service_ack(service_ack));
    function automatic logic [15:0] va(input int g, input int p);
        va = 16'(VEC_BASE_ADDR + GROUP_STRIDE * g + POS_STRIDE * p);
    endfunction : va
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // vector word tags its own address so a wrong slot shows
    task automatic wr(input int g, input int p);
        @(negedge clk);
        vec_wr_en = 1'b1;
        vec_wr_addr = va(g, p);
        vec_wr_data = {16'ha5a5, va(g, p)};
        @(negedge clk);
        vec_wr_en = 1'b0;
    endtask : wr
    task automatic pulse(input logic [95:0] m);
        @(negedge clk);
        src_irq = m;
        @(negedge clk);
        src_irq = '0;
    endtask : pulse
    // follow one service from the taking edge to handler start
    task automatic svc(input int g, input int p);
        int i;
        i = 0;
        while (!(service_ack && !service_busy) && i < 30)
        begin
            @(negedge clk);
            i++;
        end
        @(negedge clk);
        chk("busy", 1, service_busy);
        @(negedge clk);
        chk("valid", 1, vector_valid);
        chk("vector", {16'ha5a5, va(g, p)}, vector_out);
        chk("source", 32'(g * 8 + p), 32'({vector_group, vector_pos}));
        chk("flag", 0, pending_flags[g*8+p]);
        repeat (7) @(negedge clk);
        chk("start", 1, handler_start);
        chk("free", 0, service_busy);
    endtask : svc
    task automatic t_prio;
        wr(2, 0);
        wr(2, 1);
        wr(9, 0);
        lag = 4'h3;
        src_enable[17:16] = 2'h3;
        src_enable[72] = 1'b1;
        pulse((96'h1 << 72) | (96'h3 << 16));
        chk("request", 12'h204, cpu_request);
        svc(2, 0);
        svc(2, 1);
        svc(9, 0);
        chk("request", 0, cpu_request);
        $display("t_prio done");
    endtask : t_prio
    task automatic t_mask;
        wr(9, 1);
        lag = 4'h0;
        pulse((96'h1 << 73) | (96'h1 << 58) | (96'h1 << 35) | 96'h4);
        chk("pending", 1, pending_flags[73]);
        chk("reserved", 0, pending_flags[58]);
        chk("reserved 35", 0, pending_flags[35]);
        chk("reserved 2", 0, pending_flags[2]);
        chk("request", 0, cpu_request);
        src_enable[73] = 1'b1;
        @(negedge clk);
        chk("request", 12'h200, cpu_request);
        svc(9, 1);
        $display("t_mask done");
    endtask : t_mask
    // software raise on a reserved slot of the serial group
    task automatic t_soft;
        wr(8, 2);
        @(negedge clk);
        src_irq[64] = 1'b1;
        sw_raise[66] = 1'b1;
        @(negedge clk);
        src_irq = '0;
        sw_raise = '0;
        chk("raise busy", 0, pending_flags[66]);
        chk("wired", 1, pending_flags[64]);
        sw_raise[66] = 1'b1;
        @(negedge clk);
        sw_raise = '0;
        chk("raise", 1, pending_flags[66]);
        src_enable[66] = 1'b1;
        svc(8, 2);
        chk("request", 0, cpu_request);
        $display("t_soft done");
    endtask : t_soft
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // watchdog well past the roughly 85 cycles the scenarios need
    initial
    begin
        repeat (3000) @(posedge clk);
        err_total++;
        print_verdict;
    end
    initial
    begin
        {rst_n, vec_wr_en, src_irq, src_enable, sw_raise} = '0;
        {vec_wr_addr, vec_wr_data, lag} = '0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        t_prio;
        t_mask;
        t_soft;
        print_verdict;
    end
endmodule : test_irqx_expander
